// File: design/csb_chip_select_bus.sv
// chip-select decoder and strobe/acknowledge external bus sequencer
//
// The plain strobed port is this design's own decision.
`default_nettype none
module csb_chip_select_bus #(
   parameter int NUM_SEL = 4,
   parameter int ADDR_W = 24
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic clkEn,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // access requests from the core
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqIo,
   input wire logic [ADDR_W-1:0] reqAddr,
   input wire logic [7:0] reqWdata,
   output logic reqReady,
   output logic respDone,
   output logic [7:0] respRdata,
   // external bus pins
   output logic [ADDR_W-1:0] addrOut,
   output logic [7:0] dataOut,
   output logic dataOe,
   input wire logic [7:0] dataIn,
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic readNotWrite,
   input wire logic transfer_ack_n,
   output logic [NUM_SEL-1:0] chipSelectN
);
   logic [7:0] rangeLow_ff [NUM_SEL];
   logic [7:0] rangeHigh_ff [NUM_SEL];
   logic [7:0] control_ff [NUM_SEL];
   logic [7:0] busMode_ff [NUM_SEL];
   logic [NUM_SEL-1:0] hit;
   logic [NUM_SEL-1:0] regHit;
   logic [7:0] nxt_rdata;
   csb_pkg::csb_state_t state_ff, nxt_state;
   logic [3:0] cnt_ff;
   logic [3:0] stateLen_ff;
   logic [1:0] lastMode_ff;
   logic [1:0] reqMode;
   logic [3:0] reqLen;
   logic [NUM_SEL-1:0] reqSel;
   logic anyHit;
   logic isWrite_ff;
   logic [ADDR_W-1:0] addrHold_ff;
   logic [7:0] wdataHold_ff;
   logic [NUM_SEL-1:0] selHold_ff;
   logic start;
   logic lastCycle;
   logic step;

   // per-select registers, decode and register write
   genvar g;
   generate
      for (g = 0; g < NUM_SEL; g++) begin : gSel
         logic [7:0] topByte;
         logic [7:0] ioByte;
         assign topByte = reqAddr[csb_pkg::ADR_MEM_HI:csb_pkg::ADR_MEM_LO];
         assign ioByte = reqAddr[csb_pkg::ADR_IO_HI:csb_pkg::ADR_IO_LO];
         // select 0 boots as a whole-space memory select
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               rangeLow_ff[g] <= csb_pkg::RST_RANGE_LOW;
               rangeHigh_ff[g] <= (g == 0) ? csb_pkg::RST_RANGE_HIGH0 : csb_pkg::RST_RANGE_HIGH;
               control_ff[g] <= (g == 0) ? csb_pkg::RST_CONTROL0 : csb_pkg::RST_CONTROL;
               busMode_ff[g] <= csb_pkg::RST_BUS_MODE;
            end else if (clkEn && regWrite) begin
               if (regAddr == csb_pkg::OFF_RANGE_LOW[g]) begin
                  rangeLow_ff[g] <= regWdata;
               end
               if (regAddr == csb_pkg::OFF_RANGE_HIGH[g]) begin
                  rangeHigh_ff[g] <= regWdata;
               end
               // low control bits are read-only zero
               if (regAddr == csb_pkg::OFF_CONTROL[g]) begin
                  control_ff[g] <= regWdata & csb_pkg::MASK_CONTROL;
               end
               if (regAddr == csb_pkg::OFF_BUS_MODE[g]) begin
                  busMode_ff[g] <= regWdata & csb_pkg::MASK_BUS_MODE;
               end
            end
         end
         // address decode; a disabled select never matches
         always_comb begin
            if (!control_ff[g][csb_pkg::CTL_EN_BIT]) begin
               hit[g] = 1'b0;
            end else if (control_ff[g][csb_pkg::CTL_IO_BIT]) begin
               // upper bound plays no part here
               hit[g] = reqIo && (ioByte == rangeLow_ff[g]);
            end else begin
               hit[g] = !reqIo && (topByte >= rangeLow_ff[g])
                  && (topByte <= rangeHigh_ff[g]);
            end
         end
         assign regHit[g] = (regAddr == csb_pkg::OFF_RANGE_LOW[g]) || (regAddr == csb_pkg::OFF_RANGE_HIGH[g])
            || (regAddr == csb_pkg::OFF_CONTROL[g]) || (regAddr == csb_pkg::OFF_BUS_MODE[g]);
      end
   endgenerate

   // read mux; unmapped offsets read as zero
   always_comb begin
      nxt_rdata = csb_pkg::READ_ZERO;
      for (int i = 0; i < NUM_SEL; i++) begin
         if (regAddr == csb_pkg::OFF_RANGE_LOW[i]) begin
            nxt_rdata = rangeLow_ff[i];
         end
         if (regAddr == csb_pkg::OFF_RANGE_HIGH[i]) begin
            nxt_rdata = rangeHigh_ff[i];
         end
         if (regAddr == csb_pkg::OFF_CONTROL[i]) begin
            nxt_rdata = control_ff[i];
         end
         if (regAddr == csb_pkg::OFF_BUS_MODE[i]) begin
            nxt_rdata = busMode_ff[i];
         end
      end
   end

   // read data stands one cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdata <= csb_pkg::READ_ZERO;
      end else if (clkEn) begin
         regRdata <= (regRead && |regHit) ? nxt_rdata : csb_pkg::READ_ZERO;
      end
   end

   // lowest-numbered matching select wins; no match is a native access
   always_comb begin
      reqSel = '0;
      reqMode = csb_pkg::MODE_NATIVE;
      reqLen = csb_pkg::CYCLE_MIN;
      for (int i = NUM_SEL - 1; i >= 0; i--) begin
         if (hit[i]) begin
            reqSel = '0;
            reqSel[i] = 1'b1;
            reqMode = busMode_ff[i][csb_pkg::BMC_MODE_HI:csb_pkg::BMC_MODE_LO];
            reqLen = busMode_ff[i][csb_pkg::BMC_CYCLE_HI:csb_pkg::BMC_CYCLE_LO];
         end
      end
      // zero length is invalid; treat it as one cycle rather than hang
      if (reqLen == csb_pkg::CYCLE_INVALID) begin
         reqLen = csb_pkg::CYCLE_MIN;
      end
   end
   assign anyHit = |hit;

   assign start = clkEn && reqValid && (state_ff == csb_pkg::ST_IDLE);
   assign lastCycle = (cnt_ff == stateLen_ff - csb_pkg::CYCLE_MIN);
   assign step = clkEn && lastCycle;

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         csb_pkg::ST_IDLE: begin
            if (reqValid) begin
               // entering a strobed protocol from another costs one cycle; native never waits
               if (reqMode != lastMode_ff && (reqMode == csb_pkg::MODE_STROBE_ACK
                     || reqMode == csb_pkg::MODE_SEPARATE)) begin
                  nxt_state = csb_pkg::ST_EXTRA;
               end else if (reqMode == csb_pkg::MODE_STROBE_ACK) begin
                  nxt_state = csb_pkg::ST_S0;
               end else begin
                  nxt_state = csb_pkg::ST_NATIVE;
               end
            end
         end
         csb_pkg::ST_NATIVE: nxt_state = csb_pkg::ST_IDLE;
         // lastMode_ff already holds the protocol of this access here
         csb_pkg::ST_EXTRA: begin
            if (lastMode_ff == csb_pkg::MODE_STROBE_ACK) begin
               nxt_state = csb_pkg::ST_S0;
            end else begin
               nxt_state = csb_pkg::ST_NATIVE;
            end
         end
         csb_pkg::ST_S0: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S1;
            end
         end
         csb_pkg::ST_S1: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S2;
            end
         end
         csb_pkg::ST_S2: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S3;
            end
         end
         csb_pkg::ST_S3: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S4;
            end
         end
         // each wait state is one whole bus-state period
         csb_pkg::ST_S4, csb_pkg::ST_WAIT: begin
            if (lastCycle) begin
               nxt_state = transfer_ack_n ? csb_pkg::ST_WAIT : csb_pkg::ST_S5;
            end
         end
         csb_pkg::ST_S5: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S6;
            end
         end
         csb_pkg::ST_S6: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_S7;
            end
         end
         csb_pkg::ST_S7: begin
            if (lastCycle) begin
               nxt_state = csb_pkg::ST_IDLE;
            end
         end
         default: nxt_state = csb_pkg::ST_IDLE;
      endcase
   end

   // state register and per-state cycle counter
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff <= csb_pkg::ST_IDLE;
         cnt_ff <= '0;
      end else if (clkEn) begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff || lastCycle || state_ff == csb_pkg::ST_IDLE) begin
            cnt_ff <= '0;
         end else begin
            cnt_ff <= cnt_ff + 4'h1;
         end
      end
   end

   // access context latched at the request; one-cycle states keep the latched length
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stateLen_ff <= csb_pkg::CYCLE_MIN;
         isWrite_ff <= 1'b0;
         addrHold_ff <= '0;
         wdataHold_ff <= '0;
         selHold_ff <= '0;
      end else if (start) begin
         stateLen_ff <= reqLen;
         isWrite_ff <= reqWrite;
         addrHold_ff <= reqAddr;
         wdataHold_ff <= reqWdata;
         selHold_ff <= reqSel;
      end else if (clkEn && state_ff == csb_pkg::ST_EXTRA) begin
         stateLen_ff <= stateLen_ff;
      end
   end

   // protocol of the previous access, for the switch penalty
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lastMode_ff <= csb_pkg::MODE_NATIVE;
      end else if (start) begin
         // a missed decode counts as native; the switch cycle reads this back
         lastMode_ff <= anyHit ? reqMode : csb_pkg::MODE_NATIVE;
      end
   end

   // address bus and chip selects
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addrOut <= '0;
         chipSelectN <= '1;
      end else if (clkEn) begin
         if (start && nxt_state == csb_pkg::ST_NATIVE) begin
            addrOut <= reqAddr;
            chipSelectN <= ~reqSel;
         end else if (state_ff == csb_pkg::ST_EXTRA && nxt_state == csb_pkg::ST_NATIVE) begin
            addrOut <= addrHold_ff; // delayed native access drives the held copy
            chipSelectN <= ~selHold_ff;
         end else if (step && state_ff == csb_pkg::ST_S0) begin
            addrOut <= addrHold_ff;
            chipSelectN <= ~selHold_ff;
         end else if ((state_ff == csb_pkg::ST_NATIVE) || (step && state_ff == csb_pkg::ST_S7)) begin
            chipSelectN <= '1;
         end
      end
   end

   // strobes: address strobe at S2, data strobe at S2 (read) or S4 (write)
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         address_strobe_n <= 1'b1;
         data_strobe_n <= 1'b1;
      end else if (step) begin
         unique case (state_ff)
            csb_pkg::ST_S1: begin
               address_strobe_n <= 1'b0;
               data_strobe_n <= isWrite_ff;
            end
            csb_pkg::ST_S3: data_strobe_n <= 1'b0;
            // both released on the edge into S7; the acknowledge then drops
            csb_pkg::ST_S6: begin
               address_strobe_n <= 1'b1;
               data_strobe_n <= 1'b1;
            end
            default: begin
               address_strobe_n <= address_strobe_n;
               data_strobe_n <= data_strobe_n;
            end
         endcase
      end
   end

   // read-not-write and data drive
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         readNotWrite <= 1'b1;
         dataOut <= '0;
         dataOe <= 1'b0;
      end else if (clkEn) begin
         if (start) begin
            readNotWrite <= 1'b1;
         end else if (step && state_ff == csb_pkg::ST_S1 && isWrite_ff) begin
            readNotWrite <= 1'b0;
         end else if (step && state_ff == csb_pkg::ST_S7) begin
            readNotWrite <= 1'b1;
            dataOe <= 1'b0;
         end
         // write data leaves high impedance on entering S3
         if (step && state_ff == csb_pkg::ST_S2 && isWrite_ff) begin
            dataOut <= wdataHold_ff;
            dataOe <= 1'b1;
         end
      end
   end

   // read capture and completion; the peripheral drives data during S6
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         respRdata <= '0;
         respDone <= 1'b0;
         reqReady <= 1'b0;
      end else if (clkEn) begin
         if (step && state_ff == csb_pkg::ST_S6 && !isWrite_ff) begin
            respRdata <= dataIn;
         end else if (state_ff == csb_pkg::ST_NATIVE && !isWrite_ff) begin
            respRdata <= dataIn;
         end
         respDone <= (state_ff == csb_pkg::ST_NATIVE) || (step && state_ff == csb_pkg::ST_S7);
         reqReady <= (nxt_state == csb_pkg::ST_IDLE) && !start;
      end
   end
endmodule
`default_nettype wire

// File: design/csb_pkg.sv
// constants and types shared by the chip-select strobe bus block
`default_nettype none
package csb_pkg;
   // register offsets, one per select, indexed by select number
   localparam logic [7:0] OFF_RANGE_LOW [4] = '{8'ha8, 8'hab, 8'hae, 8'hb1};
   localparam logic [7:0] OFF_RANGE_HIGH [4] = '{8'ha9, 8'hac, 8'haf, 8'hb2};
   localparam logic [7:0] OFF_CONTROL [4] = '{8'haa, 8'had, 8'hb0, 8'hb3};
   localparam logic [7:0] OFF_BUS_MODE [4] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3};
   // reset values
   localparam logic [7:0] RST_RANGE_LOW = 8'h00;
   localparam logic [7:0] RST_RANGE_HIGH0 = 8'hff;
   localparam logic [7:0] RST_RANGE_HIGH = 8'h00;
   localparam logic [7:0] RST_CONTROL0 = 8'he8;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_BUS_MODE = 8'h02;
   // writable bit masks
   localparam logic [7:0] MASK_CONTROL = 8'hf8;
   localparam logic [7:0] MASK_BUS_MODE = 8'hef;
   // field positions
   localparam int CTL_IO_BIT = 4;
   localparam int CTL_EN_BIT = 3;
   localparam int BMC_MODE_HI = 7;
   localparam int BMC_MODE_LO = 6;
   localparam int BMC_CYCLE_HI = 3;
   localparam int BMC_CYCLE_LO = 0;
   // address bytes seen by the decoder
   localparam int ADR_MEM_HI = 23;
   localparam int ADR_MEM_LO = 16;
   localparam int ADR_IO_HI = 15;
   localparam int ADR_IO_LO = 8;
   // protocol codes of the bus mode field
   localparam logic [1:0] MODE_NATIVE = 2'h0;
   localparam logic [1:0] MODE_LEGACY = 2'h1;
   localparam logic [1:0] MODE_SEPARATE = 2'h2;
   localparam logic [1:0] MODE_STROBE_ACK = 2'h3;
   localparam logic [3:0] CYCLE_INVALID = 4'h0;
   localparam logic [3:0] CYCLE_MIN = 4'h1;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // bus sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_NATIVE = 4'b0001,
      ST_EXTRA = 4'b0010,
      ST_S0 = 4'b0011,
      ST_S1 = 4'b0100,
      ST_S2 = 4'b0101,
      ST_S3 = 4'b0110,
      ST_S4 = 4'b0111,
      ST_WAIT = 4'b1000,
      ST_S5 = 4'b1001,
      ST_S6 = 4'b1010,
      ST_S7 = 4'b1011
   } csb_state_t;
endpackage
`default_nettype wire

// File: verification/csb_chip_select_bus_bench.sv
// self-checking bench for the chip-select strobe bus block
`default_nettype none
module csb_chip_select_bus_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, srst, clkEn, regWrite, regRead, reqValid, reqWrite, reqIo, reqReady, respDone, dataOe;
   logic address_strobe_n, data_strobe_n, readNotWrite, transfer_ack_n;
   logic [7:0] regAddr, regWdata, regRdata, reqWdata, respRdata, dataOut, dataIn, rdVal, wrSeen;
   logic [23:0] reqAddr, addrOut;
   logic [3:0] chipSelectN, csLow, ackDelay;
   int failures, n_tests;
   csb_chip_select_bus dut_u (.sys_clk, .srst, .clkEn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .reqValid, .reqWrite, .reqIo, .reqAddr, .reqWdata, .reqReady, .respDone, .respRdata, .addrOut, .dataOut,
      .dataOe, .dataIn, .address_strobe_n, .data_strobe_n, .readNotWrite, .transfer_ack_n, .chipSelectN);
   csb_periph_model peer_u (.sys_clk, .data_strobe_n, .readNotWrite, .dataOe, .dataOut, .rdVal, .ackDelay,
      .transfer_ack_n, .dataIn, .wrSeen);
   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // sticky record of selects seen low, cleared at the taking edge; native selects last one cycle
   always @(posedge sys_clk) csLow <= (reqValid && reqReady) ? 4'h0 : csLow | ~chipSelectN;
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRead <= 1'b0;
      @(negedge sys_clk);
      d = regRdata;
   endtask
   // one access; lat counts cycles from the taking edge to done
   task automatic acc(input logic w, input logic io, input logic [23:0] a, input logic [7:0] d, output logic [7:0] lat);
      do @(negedge sys_clk); while (reqReady !== 1'b1);
      @(posedge sys_clk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqIo <= io;
      reqAddr <= a;
      reqWdata <= d;
      @(posedge sys_clk);
      reqValid <= 1'b0;
      lat = 8'h00;
      do begin
         @(negedge sys_clk);
         lat++;
      end while (respDone !== 1'b1 && lat < 8'hc8);
   endtask
   task automatic t_regs();
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         rd(csb_pkg::OFF_RANGE_LOW[i], v);
         chk("range low reset", 8'h00, v);
         rd(csb_pkg::OFF_RANGE_HIGH[i], v);
         chk("range high reset", (i == 0) ? 8'hff : 8'h00, v);
      end
      wr(8'h10, 8'h5a);
      rd(8'h10, v);
      chk("unmapped read", 8'h00, v);
      wr(csb_pkg::OFF_RANGE_HIGH[3], 8'hc3);
      rd(csb_pkg::OFF_RANGE_HIGH[3], v);
      chk("range high rw", 8'hc3, v);
      // a write while the clock enable is low must not land
      clkEn <= 1'b0;
      wr(csb_pkg::OFF_RANGE_HIGH[3], 8'h77);
      clkEn <= 1'b1;
      rd(csb_pkg::OFF_RANGE_HIGH[3], v);
      chk("frozen write", 8'hc3, v);
   endtask
   // both bounds inclusive, one below and above, then disabled
   task automatic t_mem();
      logic [7:0] hi [5] = '{8'h0f, 8'h10, 8'h1f, 8'h20, 8'h10};
      logic [3:0] ex [5] = '{4'h0, 4'h2, 4'h2, 4'h0, 4'h0};
      logic [7:0] lat;
      wr(csb_pkg::OFF_CONTROL[0], 8'h00);
      wr(csb_pkg::OFF_RANGE_LOW[1], 8'h10);
      wr(csb_pkg::OFF_RANGE_HIGH[1], 8'h1f);
      for (int i = 0; i < 5; i++) begin
         wr(csb_pkg::OFF_CONTROL[1], (i == 4) ? 8'h00 : 8'h08);
         acc(1'b0, 1'b0, {hi[i], 16'h0000}, 8'h00, lat);
         chk("memory select", ex[i], csLow);
         chk("native latency", 8'h02, lat);
      end
   endtask
   // upper bound below the match value must not matter
   task automatic t_io();
      logic [7:0] lat;
      wr(csb_pkg::OFF_RANGE_LOW[2], 8'h55);
      wr(csb_pkg::OFF_CONTROL[2], 8'h18);
      acc(1'b1, 1'b1, 24'h005500, 8'h00, lat);
      chk("io select hit", 4'h4, csLow);
      acc(1'b1, 1'b1, 24'h005600, 8'h00, lat);
      chk("io select miss", 4'h0, csLow);
   endtask
   task automatic t_strobe();
      logic [7:0] lat;
      wr(csb_pkg::OFF_RANGE_LOW[3], 8'h40);
      wr(csb_pkg::OFF_RANGE_HIGH[3], 8'h40);
      wr(csb_pkg::OFF_CONTROL[3], 8'h08);
      wr(csb_pkg::OFF_CONTROL[1], 8'h08);
      wr(csb_pkg::OFF_BUS_MODE[3], 8'hc1);
      acc(1'b1, 1'b0, 24'h400000, 8'ha5, lat);
      chk("switch latency", 8'h0a, lat);
      chk("written data", 8'ha5, wrSeen);
      chk("address bus", 24'h400000, addrOut);
      chk("rnw restored", 1'b1, readNotWrite);
      acc(1'b1, 1'b0, 24'h40ff00, 8'h3c, lat);
      chk("repeat latency", 8'h09, lat);
      chk("strobe select", 4'h8, csLow);
      ackDelay = 4'h2;
      acc(1'b1, 1'b0, 24'h400000, 8'h69, lat);
      chk("wait latency", 8'h0b, lat);
      ackDelay = 4'h0;
      rdVal = 8'h96;
      acc(1'b0, 1'b0, 24'h400000, 8'h00, lat);
      chk("read data", 8'h96, respRdata);
      acc(1'b0, 1'b0, 24'h120000, 8'h00, lat);
      chk("to native latency", 8'h02, lat);
      wr(csb_pkg::OFF_BUS_MODE[1], 8'h82);
      acc(1'b0, 1'b0, 24'h120000, 8'h00, lat);
      chk("to separate latency", 8'h03, lat);
      chk("separate select", 4'h2, csLow);
      wr(csb_pkg::OFF_BUS_MODE[3], 8'hc2);
      acc(1'b0, 1'b0, 24'h400000, 8'h00, lat);
      chk("length latency", 8'h08 * 8'h02 + 8'h02, lat);
      acc(1'b0, 1'b0, 24'h120000, 8'h00, lat);
      chk("strobe to separate", 8'h03, lat);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      srst = 1'b1;
      clkEn = 1'b1;
      {regWrite, regRead, reqValid, reqWrite, reqIo} = 5'h00;
      {regAddr, regWdata, reqWdata, rdVal} = 32'h0;
      reqAddr = 24'h0;
      ackDelay = 4'h0;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_mem();
      t_io();
      t_strobe();
      complete_run();
   end
   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      #100000;
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire

// File: verification/csb_chip_select_bus_chk.sv
// concurrent checks on the strobe bus pins of the chip-select block
`default_nettype none
module csb_chip_select_bus_chk #(
   parameter int NUM_SEL = 4,
   parameter int ADDR_W = 24
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [ADDR_W-1:0] addrOut,
   input wire logic [7:0] dataOut,
   input wire logic dataOe,
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic readNotWrite,
   input wire logic transfer_ack_n,
   input wire logic [NUM_SEL-1:0] chipSelectN
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // data strobe only ever inside the address strobe window
   a_ds_in_as: assert property (!data_strobe_n |-> !address_strobe_n)
      else $error("data strobe outside address strobe");
   a_rnw_with_as: assert property ($fell(readNotWrite) |-> $fell(address_strobe_n))
      else $error("read-not-write fell apart from address strobe");
   a_strobes_drop: assert property ($rose(address_strobe_n) |-> $rose(data_strobe_n))
      else $error("strobes not removed together");
   a_rnw_restore: assert property ($rose(address_strobe_n) && !readNotWrite |-> ##[1:15] readNotWrite)
      else $error("read-not-write not restored after write");
   // write data must already be on the bus one cycle before the data strobe
   a_data_driven: assert property ($fell(data_strobe_n) && !readNotWrite |-> dataOe && $past(dataOe))
      else $error("write data not driven before data strobe");
   a_wait_ack: assert property (!data_strobe_n && transfer_ack_n |=> !data_strobe_n)
      else $error("strobe removed without acknowledge");
   a_addr_hold: assert property (!address_strobe_n |=> address_strobe_n || $stable(addrOut))
      else $error("address moved under address strobe");
   a_wdata_hold: assert property (!data_strobe_n && !readNotWrite |=> $stable(dataOut))
      else $error("write data moved under data strobe");
   a_cs_leads_as: assert property ($fell(address_strobe_n) |-> !(&$past(chipSelectN)))
      else $error("address strobe without a select");
   a_one_select: assert property ($onehot0(~chipSelectN))
      else $error("more than one select asserted");
endmodule
bind csb_chip_select_bus csb_chip_select_bus_chk #(.NUM_SEL(NUM_SEL), .ADDR_W(ADDR_W)) chk_u (
   .sys_clk(sys_clk), .srst(srst), .addrOut(addrOut), .dataOut(dataOut), .dataOe(dataOe),
   .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n), .readNotWrite(readNotWrite),
   .transfer_ack_n(transfer_ack_n), .chipSelectN(chipSelectN));
`default_nettype wire

// File: verification/csb_periph_model.sv
// external peripheral answering the strobe bus with an acknowledge
`default_nettype none
module csb_periph_model (
   input wire logic sys_clk,
   input wire logic data_strobe_n,
   input wire logic readNotWrite,
   input wire logic dataOe,
   input wire logic [7:0] dataOut,
   input wire logic [7:0] rdVal,
   input wire logic [3:0] ackDelay,
   output logic transfer_ack_n,
   output logic [7:0] dataIn,
   output logic [7:0] wrSeen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt = 4'h0;
   initial dataIn = 8'h00;
   initial wrSeen = 8'h00;
   // ack after ackDelay cycles of strobe; freed with the strobe, no hold
   assign transfer_ack_n = data_strobe_n | (cnt < ackDelay);
   // count strobe cycles, drive read data, take write data on ack
   always @(posedge sys_clk) begin
      cnt <= data_strobe_n ? 4'h0 : cnt + 4'h1;
      // released bus toggles so a stale value never looks valid
      dataIn <= (readNotWrite && !data_strobe_n) ? rdVal : ~dataIn;
      if (!transfer_ack_n && !readNotWrite && dataOe) begin
         wrSeen <= dataOut;
      end
   end
endmodule
`default_nettype wire
